// [core/banked_data_memory_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmem_defines.svh"


module banked_data_memory_decoder
  import dmem_pkg::*;
#(
  parameter int RAM_DEPTH = `DM_RAM_DEPTH,
  parameter int WB_AW     = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // core operand port
  input  wire logic             cpu_req_i,
  input  wire logic             cpu_we_i,
  input  wire logic [6:0]       cpu_addr_i,
  input  wire logic [7:0]       cpu_wdata_i,
  output logic [7:0]            cpu_rdata_o,
  // program counter hand-off with the core
  input  wire logic             pc_low_load_i,
  input  wire logic [7:0]       pc_low_i,
  output logic [7:0]            pc_low_o,
  output logic [7:0]            pc_upper_o,
  output logic                  pc_low_wr_o,
  output logic [7:0]            status_o,
  // peripheral register window
  output logic                  periph_sel_o,
  output logic                  periph_we_o,
  output logic [8:0]            periph_addr_o,
  output logic [7:0]            periph_wdata_o,
  input  wire logic [7:0]       periph_rdata_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]         status_q;
  logic [7:0]         pointer_q;
  logic [7:0]         pc_low_q;
  logic [7:0]         pc_upper_q;
  logic [7:0]         cpu_rdata_q;
  logic [31:0]        wb_dat_q;
  logic               wb_ack_q;

  logic [WB_AW-3:0]   wb_idx;
  logic               wb_mapped;
  logic               wb_req;
  logic               acc_go;
  logic               acc_we;
  logic [7:0]         acc_wdata;
  dm_addr_t           dir_addr;
  dm_addr_t           eff_addr;
  logic               via_pointer;
  target_t            dec_tgt;
  target_t            tgt;
  logic [6:0]         ram_idx;
  logic [7:0]         ram_rdata;
  logic [7:0]         rd_val;
  logic               wr;

  //////////////////////////////////////////////////////////////////////////////
  // bus side: wishbone words map one data address each

  // word index is the nine-bit data address; higher indexes are unmapped
  assign wb_idx    = wb_adr_i[WB_AW-1:2];
  assign wb_mapped = ~|wb_idx[WB_AW-3:9];

  // the core owns the array in any cycle it asks; the bus simply waits
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q & ~cpu_req_i;

  //////////////////////////////////////////////////////////////////////////////
  // access source selection

  // one access per clock, from the core or from the bus
  assign acc_go = cpu_req_i | (wb_req & wb_mapped);

  // only byte lane 0 carries data, so a write without it stores nothing
  assign acc_we    = cpu_req_i ? cpu_we_i : (wb_we_i & wb_sel_i[0]);
  assign acc_wdata = cpu_req_i ? cpu_wdata_i : wb_dat_i[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // address formation

  // direct address: bank pair from status above the opcode bits
  always_comb begin
    if (cpu_req_i) begin
      dir_addr = {status_q[`DM_ST_BANK_HI],
                  status_q[`DM_ST_BANK_LO],
                  cpu_addr_i};
    end else begin
      dir_addr = wb_idx[8:0];
    end
  end

  // the indirect port in any bank redirects through the pointer
  assign via_pointer = (dir_addr[6:0] == `DM_OFS_IND_PORT);

  // pointer and bank bit are taken live, so a write lands next cycle
  assign eff_addr = via_pointer ? {status_q[`DM_ST_IND_BANK], pointer_q}
                                : dir_addr;

  //////////////////////////////////////////////////////////////////////////////
  // decode

  // region split and bank folding live in the decoder
  dmem_decode u_decode (
    .addr_i    (eff_addr),
    .tgt_o     (dec_tgt),
    .ram_idx_o (ram_idx)
  );

  // a pointer aimed at the port itself has nothing behind it
  always_comb begin
    tgt = dec_tgt;
    if (via_pointer && dec_tgt == TGT_IND_PORT) begin
      tgt = TGT_NONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // general ram, bank 0 and bank 1 cells plus the shared rows

  assign wr = acc_go & acc_we;

  dmem_store #(
    .WIDTH (8),
    .DEPTH (RAM_DEPTH),
    .AW    (`DM_RAM_IDX_W)
  ) u_store (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (wr && tgt == TGT_RAM),
    .waddr_i (ram_idx),
    .wdata_i (acc_wdata),
    .raddr_i (ram_idx),
    .rdata_o (ram_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read multiplexer

  // anything unimplemented falls through to zero
  always_comb begin
    case (tgt)
      TGT_RAM:      rd_val = ram_rdata;
      TGT_PC_LOW:   rd_val = pc_low_q;
      TGT_STATUS:   rd_val = status_q;
      TGT_POINTER:  rd_val = pointer_q;
      TGT_PC_UPPER: rd_val = pc_upper_q;
      TGT_PERIPH:   rd_val = periph_rdata_i;
      default:      rd_val = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // core registers, each a static byte shared by all banks

  // status: bank select and indirect bank bits live here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= `DM_RST_STATUS;
    end else if (wr && tgt == TGT_STATUS) begin
      status_q <= acc_wdata;
    end
  end

  // pointer used for every indirect access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pointer_q <= `DM_RST_POINTER;
    end else if (wr && tgt == TGT_POINTER) begin
      pointer_q <= acc_wdata;
    end
  end

  // program counter low: a data write beats the core's own reload,
  // because the write is how software performs a computed jump
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_low_q <= `DM_RST_PC_LOW;
    end else if (wr && tgt == TGT_PC_LOW) begin
      pc_low_q <= acc_wdata;
    end else if (pc_low_load_i) begin
      pc_low_q <= pc_low_i;
    end
  end

  // upper program counter latch, read by the core on jumps and by data reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_upper_q <= `DM_RST_PC_UPPER;
    end else if (wr && tgt == TGT_PC_UPPER) begin
      pc_upper_q <= acc_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core answer

  // read data is captured at the edge that ends the access cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_rdata_q <= 8'h00;
    end else if (cpu_req_i && !cpu_we_i) begin
      cpu_rdata_q <= rd_val;
    end
  end

  assign cpu_rdata_o = cpu_rdata_q;
  assign pc_low_o    = pc_low_q;
  assign pc_upper_o  = pc_upper_q;
  assign status_o    = status_q;

  // tells the core that software replaced the program counter low byte
  assign pc_low_wr_o = wr && tgt == TGT_PC_LOW;

  //////////////////////////////////////////////////////////////////////////////
  // peripheral window

  // peripheral registers stay outside; they see the same single-cycle slot
  assign periph_sel_o   = acc_go && tgt == TGT_PERIPH;
  assign periph_we_o    = acc_go && acc_we && tgt == TGT_PERIPH;
  assign periph_addr_o  = eff_addr;
  assign periph_wdata_o = acc_wdata;

  //////////////////////////////////////////////////////////////////////////////
  // bus answer

  // ack rises the edge after the request is taken and lasts one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
    end else begin
      wb_ack_q <= wb_req;
    end
  end

  // unmapped words answer zero but still acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_q <= 32'h0000_0000;
    end else if (wb_req) begin
      wb_dat_q <= {24'h00_0000, wb_mapped ? rd_val : 8'h00};
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

endmodule
`default_nettype wire

// [core/dmem_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmem_defines.svh"

module dmem_decode
  import dmem_pkg::*;
(
  input  wire dm_addr_t   addr_i,
  output target_t         tgt_o,
  output logic [6:0]      ram_idx_o
);

  logic [1:0] bank;
  logic [6:0] ofs;

  assign bank = addr_i[8:7];
  assign ofs  = addr_i[6:0];

  // map a nine-bit address onto a register, a ram cell or nothing
  always_comb begin
    tgt_o     = TGT_NONE;
    ram_idx_o = 7'h00;
    if (ofs < `DM_SFR_TOP) begin
      case (ofs)
        `DM_OFS_IND_PORT: tgt_o = TGT_IND_PORT;
        `DM_OFS_PC_LOW:   tgt_o = TGT_PC_LOW;
        `DM_OFS_STATUS:   tgt_o = TGT_STATUS;
        `DM_OFS_POINTER:  tgt_o = TGT_POINTER;
        `DM_OFS_PC_UPPER: tgt_o = TGT_PC_UPPER;
        default:          tgt_o = TGT_PERIPH;
      endcase
    end else if (ofs >= `DM_SHARED_BASE || bank == 2'b00) begin
      // shared top rows fold onto bank 0, so the index ignores the bank
      tgt_o     = TGT_RAM;
      ram_idx_o = ofs - `DM_SFR_TOP;
    end else if (bank == 2'b01 && ofs < `DM_BANK1_TOP) begin
      tgt_o     = TGT_RAM;
      ram_idx_o = ofs - `DM_SFR_TOP + `DM_BANK0_SIZE;
    end
  end

endmodule
`default_nettype wire

// [core/dmem_store.sv]
`timescale 1ns/1ps
`default_nettype none

module dmem_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic [WIDTH-1:0]      rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // cleared at reset so reads never show undefined cells
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[raddr_i];

endmodule
`default_nettype wire

// [include/dmem_defines.svh]
`ifndef DMEM_DEFINES_SVH
`define DMEM_DEFINES_SVH

// geometry of one bank and of the whole space
`define DM_ADDR_W        9
`define DM_OFS_W         7
`define DM_RAM_DEPTH     128
`define DM_RAM_IDX_W     7

// in-bank offsets of the core registers
`define DM_OFS_IND_PORT  7'h00
`define DM_OFS_PC_LOW    7'h02
`define DM_OFS_STATUS    7'h03
`define DM_OFS_POINTER   7'h04
`define DM_OFS_PC_UPPER  7'h0a

// region limits inside a bank
`define DM_SFR_TOP       7'h20
`define DM_SHARED_BASE   7'h70
`define DM_BANK1_TOP     7'h40
`define DM_BANK0_SIZE    7'h60

// status bit positions
`define DM_ST_BANK_LO    5
`define DM_ST_BANK_HI    6
`define DM_ST_IND_BANK   7

// reset values of the core registers
`define DM_RST_STATUS    8'h00
`define DM_RST_POINTER   8'h00
`define DM_RST_PC_LOW    8'h00
`define DM_RST_PC_UPPER  8'h00

`endif

// [include/dmem_pkg.sv]
package dmem_pkg;

  // what a decoded data address lands on
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_IND_PORT,
    TGT_PC_LOW,
    TGT_STATUS,
    TGT_POINTER,
    TGT_PC_UPPER,
    TGT_PERIPH,
    TGT_RAM
  } target_t;

  typedef logic [8:0] dm_addr_t;

endpackage

// [tb/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       clk_i,
  output logic            req_o,
  output logic            we_o,
  output logic [6:0]      addr_o,
  output logic [7:0]      wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // one operand access owning the port for one cycle; released data is inverted
  task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    req_o <= 1'b0;
    wdata_o <= ~d;
    @(negedge clk_i);
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// [tb/dmem_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module dmem_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cpu_req_i,
  input wire logic        cpu_we_i,
  input wire logic [6:0]  cpu_addr_i,
  input wire logic [7:0]  cpu_wdata_i,
  input wire logic [7:0]  cpu_rdata_o,
  input wire logic        pc_low_load_i,
  input wire logic [7:0]  pc_low_i,
  input wire logic [7:0]  pc_low_o,
  input wire logic        pc_low_wr_o,
  input wire logic [7:0]  status_o,
  input wire logic        periph_sel_o,
  input wire logic [8:0]  periph_addr_o,
  input wire logic [7:0]  periph_rdata_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // bus take needs an idle core, since the core wins the port
  sequence wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !cpu_req_i;
  endsequence
  sequence cpu_rd;
    cpu_req_i && !cpu_we_i;
  endsequence
  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_after_take_a: assert property (wb_take |=> wb_ack_o) else $error("no ack");
  ack_core_idle_a: assert property (wb_ack_o |-> !$past(cpu_req_i) && $past(wb_stb_i)) else $error("bad ack");
  direct_addr_a: assert property (cpu_req_i && cpu_addr_i != 7'h00
    |-> periph_addr_o == {status_o[6:5], cpu_addr_i}) else $error("bad address");
  sfr_window_a: assert property (periph_sel_o |-> periph_addr_o[6:0] < 7'h20) else $error("bad window");
  periph_read_a: assert property (cpu_rd ##0 periph_sel_o
    |=> cpu_rdata_o == $past(periph_rdata_i)) else $error("bad periph data");
  unimpl_zero_a: assert property (cpu_rd ##0 (status_o[6:5] == 2'b01 && cpu_addr_i inside {[7'h40:7'h6f]})
    |=> cpu_rdata_o == 8'h00) else $error("hole not zero");
  pc_write_a: assert property (cpu_req_i && cpu_we_i && cpu_addr_i == 7'h02
    |-> pc_low_wr_o ##1 pc_low_o == $past(cpu_wdata_i)) else $error("pc write lost");
  pc_load_a: assert property (pc_low_load_i && !pc_low_wr_o |=> pc_low_o == $past(pc_low_i)) else $error("pc load");
  bank_write_a: assert property (cpu_req_i && cpu_we_i && cpu_addr_i == 7'h03
    |=> {status_o[7:5], 5'h00} == ($past(cpu_wdata_i) & 8'he0)) else $error("bank bits");
  dat_high_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("high lanes");
endmodule
bind banked_data_memory_decoder dmem_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i),
  .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .pc_low_load_i(pc_low_load_i), .pc_low_i(pc_low_i),
  .pc_low_o(pc_low_o), .pc_low_wr_o(pc_low_wr_o), .status_o(status_o), .periph_sel_o(periph_sel_o),
  .periph_addr_o(periph_addr_o), .periph_rdata_i(periph_rdata_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
`default_nettype wire

// [tb/test_banked_data_memory_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module test_banked_data_memory_decoder;
  logic        clk_i, rst_i, req, we, ld, cyc, stb, wwe, ack;
  logic [6:0]  adr;
  logic [7:0]  wd, rd, program_counter_low, pin, stw, pcu, prd, r, d, st;
  logic [11:0] wadr;
  logic [3:0]  wsel;
  logic [31:0] wdat, wdo;
  logic [8:0]  a;
  logic [7:0]  mem [512];
  int          err_total, checks, m;
  logic        sel_on;
  banked_data_memory_decoder uut (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(req), .cpu_we_i(we),
    .cpu_addr_i(adr), .cpu_wdata_i(wd), .cpu_rdata_o(rd), .pc_low_load_i(ld), .pc_low_i(pin),
    .pc_low_o(program_counter_low), .pc_upper_o(pcu), .pc_low_wr_o(), .status_o(stw), .periph_sel_o(),
    .periph_we_o(), .periph_addr_o(), .periph_wdata_o(), .periph_rdata_i(prd), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(wsel), .wb_dat_i(wdat),
    .wb_dat_o(wdo), .wb_ack_o(ack));
  core_model u_core (.clk_i(clk_i), .req_o(req), .we_o(we), .addr_o(adr), .wdata_o(wd), .rdata_i(rd));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  // physical cell behind a nine-bit address, -1 for a hole
  function automatic int canon(logic [8:0] x);
    if (x[6:0] >= 7'h70) return int'(x[6:0]);
    if (x[6:0] >= 7'h20 && (x[8:7] == 2'b00 || (x[8:7] == 2'b01 && x[6:0] < 7'h40))) return int'(x);
    return -1;
  endfunction
  function automatic logic [7:0] expect_at(logic [8:0] x);
    return canon(x) >= 0 ? mem[canon(x)] : 8'h00;
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bank through status, then the in-bank offset; the shadow keeps status
  task automatic dacc(logic w, logic [8:0] x, logic [7:0] v, output logic [7:0] q);
    st = {st[7], x[8:7], 5'h00};
    u_core.op(1'b1, 7'h03, st, q);
    u_core.op(w, x[6:0], v, q);
  endtask
  task automatic iacc(logic w, logic [8:0] x, logic [7:0] v, output logic [7:0] q);
    u_core.op(1'b1, 7'h04, x[7:0], q);
    st = {x[8], st[6:5], 5'h00};
    u_core.op(1'b1, 7'h03, st, q);
    u_core.op(w, 7'h00, v, q);
  endtask
  task automatic wbx(logic w, logic [11:0] x, logic s, logic [7:0] v, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    wadr <= x;
    wsel <= {3'b000, s};
    wdat <= {24'h0, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = wdo[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~wdat;
    chk({7'h00, ack}, 8'h01);
  endtask
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  initial begin
    void'($urandom(4));
    {rst_i, ld, cyc, stb, wwe, wadr, wsel, wdat, pin, st} = '1;
    {ld, cyc, stb, st} = '0;
    prd = 8'h5a;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(stw, 8'h00);
    chk(program_counter_low, 8'h00);
    chk(pcu, 8'h00);
    // random writes and reads over all three access paths
    repeat (300) begin
      a = 9'($urandom) | 9'h020;
      d = 8'($urandom);
      m = $urandom % 3;
      if (m == 0) dacc(1'b1, a, d, r);
      else if (m == 1) iacc(1'b1, a, d, r);
      else begin
        // a write without lane 0 stores nothing, so the shadow is left alone
        sel_on = ($urandom % 4) != 0;
        wbx(1'b1, {1'b0, a, 2'b00}, sel_on, d, r);
        if (!sel_on) m = 3;
      end
      if (canon(a) >= 0 && m != 3) mem[canon(a)] = d;
      a = 9'($urandom) | 9'h020;
      m = $urandom % 3;
      if (m == 0) dacc(1'b0, a, 8'h00, r);
      else if (m == 1) iacc(1'b0, a, 8'h00, r);
      else wbx(1'b0, {1'b0, a, 2'b00}, 1'b1, 8'h00, r);
      chk(r, expect_at(a));
    end
    // core registers seen from every bank
    for (int b = 0; b < 4; b++) begin
      d = 8'($urandom);
      dacc(1'b1, {2'(b), 7'h02}, d, r);
      dacc(1'b0, {2'(3 - b), 7'h02}, 8'h00, r);
      chk(r, d);
      dacc(1'b0, {2'(b), 7'h05}, 8'h00, r);
      chk(r, prd);
      dacc(1'b1, {2'(b), 7'h0a}, d, r);
      chk(pcu, d);
    end
    @(posedge clk_i);
    ld <= 1'b1;
    pin <= 8'hc3;
    @(posedge clk_i);
    ld <= 1'b0;
    @(negedge clk_i);
    chk(program_counter_low, 8'hc3);
    iacc(1'b0, 9'h080, 8'h00, r);
    chk(r, 8'h00);
    wbx(1'b0, 12'h804, 1'b1, 8'h00, r);
    chk(r, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
